// ### logic/disk_host_port.sv
`timescale 1ns/1ns

// ============================================================================
// link side: ultra DMA sender on the strobe clock
module udma_link (
  input  wire logic        link_clock,
  input  wire logic        reset,
  input  wire logic        burst,
  input  wire logic        req_toggle,
  input  wire logic [15:0] word,
  output      logic        ack_toggle,
  output      logic [15:0] udma_dd,
  output      logic        udma_dd_oe_n,
  output      logic        udma_dstrobe
);
  typedef struct packed {
    logic        rst_s1, rst_s2;
    logic        act_s1, act_s2;
    logic        req_s1, req_s2, req_s3;
    logic        pend;
    logic [15:0] dd;
    logic        strobe;
    logic        ack;
    logic        oe_n;
  } link_t;
  link_t q, n;

  // a new word settles on the bus one cycle, then the strobe edge launches it
  always_comb begin
    n = q;
    n.rst_s1 = reset;
    n.rst_s2 = q.rst_s1;
    n.act_s1 = burst;
    n.act_s2 = q.act_s1;
    n.req_s1 = req_toggle;
    n.req_s2 = q.req_s1;
    n.req_s3 = q.req_s2;
    n.oe_n   = ~q.act_s2;
    if (q.pend) begin
      n.strobe = ~q.strobe;
      n.ack    = ~q.ack;
      n.pend   = 1'b0;
    end else if (q.req_s2 != q.req_s3) begin
      n.dd   = word;
      n.pend = 1'b1;
    end
    if (q.rst_s2) begin
      n.pend   = 1'b0;
      n.strobe = 1'b0;
      n.ack    = q.req_s3;
      n.oe_n   = 1'b1;
    end
  end

  always_ff @(posedge link_clock) begin
    q <= n;
  end

  assign ack_toggle   = q.ack;
  assign udma_dd      = q.dd;
  assign udma_dd_oe_n = q.oe_n;
  assign udma_dstrobe = q.strobe;
endmodule : udma_link

// ============================================================================
// core: host registers, reset, interrupt and read command engine
module disk_host_port #(
  parameter int SECTOR_WORDS = 256,
  parameter int ECC_WORDS    = 2,
  parameter int SPT          = 63,
  parameter int HEADS        = 16,
  parameter int INIT_CYCLES  = disk_pkg::INIT_CYCLES_DEF
) (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        link_clock,
  input  wire logic        host_reset_n,
  input  wire logic [9:0]  host_addr,
  input  wire logic        host_rd_n,
  input  wire logic        host_wr_n,
  input  wire logic [15:0] dd_in,
  output      logic [15:0] dd_out,
  output      logic [15:0] dd_oe_n,
  output      logic        host_irq,
  output      logic        host_irq_oe_n,
  output      logic        dmarq,
  input  wire logic        dmack_n,
  input  wire logic        udma_mode,
  output      logic [15:0] udma_dd,
  output      logic        udma_dd_oe_n,
  output      logic        udma_dstrobe,
  input  wire logic        write_gate_n,
  output      logic        seek_start,
  output      logic [15:0] seek_cyl,
  input  wire logic        seek_done,
  output      logic        media_start,
  output      logic [15:0] media_cyl,
  output      logic [3:0]  media_head,
  output      logic [7:0]  media_sector,
  output      logic        media_long,
  output      logic        media_retry,
  input  wire logic        media_valid,
  input  wire logic [15:0] media_word,
  input  wire logic        media_end,
  input  wire logic        media_dam_err,
  input  wire logic        media_data_err
);
  import disk_pkg::*;
  localparam int DEPTH = SECTOR_WORDS + ECC_WORDS;
  localparam int PW    = $clog2(DEPTH + 1);

  typedef enum logic [2:0] {ST_INIT, ST_IDLE, ST_SEEK, ST_MEDIA, ST_PIO, ST_DMA} state_t;
  typedef struct packed {
    logic                   rd_s1, rd_s2, rd_s3, wr_s1, wr_s2, wr_s3;
    logic                   hrst_s1, hrst_s2, ack_s1, ack_s2, wg_s1, wg_s2;
    logic                   um_s1, um_s2, lack_s1, lack_s2;
    logic [9:0]             addr_s1, addr_s2;
    logic [15:0]            din_s1, din_s2;
    logic                   soft_reset_bit, mask;
    logic [7:0]             err, scnt, snum, dh;
    logic [15:0]            cyl, cur_cyl;
    logic                   busy, drdy, dsc, drq, errb, irq_pend;
    logic                   lng, verify, dma, failed;
    logic [8:0]             remain;
    state_t                 state;
    logic [15:0]            init_cnt;
    logic [DEPTH-1:0][15:0] buffer;
    logic [PW-1:0]          wptr, rptr;
    logic [15:0]            dout, oe_n;
    logic                   seek_go, media_go, dmarq, burst, lreq;
    logic [15:0]            lword;
  } core_t;
  core_t q, n;
  logic  rd_start, wr_end, hw_clear, fin, fin_irq, last_word, udma_ack;
  logic  [8:0] count_req;

  // status byte is read at two ports
  function automatic logic [7:0] status_byte(input core_t s);
    status_byte = {s.busy, s.drdy, 1'b0, s.dsc, s.drq, 2'b00, s.errb};
  endfunction : status_byte

  // next sector address: sector wraps to 1, then head, then cylinder
  function automatic logic [27:0] next_addr(input logic [7:0] sn, input logic [3:0] hd,
                                            input logic [15:0] cy);
    next_addr = {cy, hd, sn + 8'h01};
    if (sn >= 8'(SPT)) begin
      next_addr[7:0]  = 8'h01;
      next_addr[11:8] = hd + 4'h1;
      if (hd >= 4'(HEADS - 1)) begin
        next_addr[11:8]  = 4'h0;
        next_addr[27:12] = cy + 16'h0001;
      end
    end
  endfunction : next_addr

  // ==========================================================================
  // host strobes cross from the pins; reads act on the leading edge, writes
  // on the trailing one so the synchronised data is settled
  assign rd_start  = q.rd_s2 & ~q.rd_s3;
  assign wr_end    = q.wr_s3 & ~q.wr_s2;
  assign last_word = (q.rptr + PW'(1)) == q.wptr;
  assign count_req = (q.scnt == 8'h00) ? SECTORS_MAX : {1'b0, q.scnt};

  always_comb begin
    n = q;
    fin = 1'b0;
    fin_irq = 1'b0;
    hw_clear = 1'b0;
    n.rd_s1 = ~host_rd_n;   n.rd_s2 = q.rd_s1;   n.rd_s3 = q.rd_s2;
    n.wr_s1 = ~host_wr_n;   n.wr_s2 = q.wr_s1;   n.wr_s3 = q.wr_s2;
    n.hrst_s1 = ~host_reset_n;   n.hrst_s2 = q.hrst_s1;
    n.ack_s1 = ~dmack_n;    n.ack_s2 = q.ack_s1;
    n.wg_s1 = write_gate_n; n.wg_s2 = q.wg_s1;
    n.um_s1 = udma_mode;    n.um_s2 = q.um_s1;
    n.lack_s1 = udma_ack;   n.lack_s2 = q.lack_s1;
    n.addr_s1 = host_addr;  n.addr_s2 = q.addr_s1;
    n.din_s1 = dd_in;       n.din_s2 = q.din_s1;
    n.seek_go = 1'b0;
    n.media_go = 1'b0;
    if (!q.rd_s2) n.oe_n = 16'hffff;

    // host reads: data port pops, status read clears the interrupt
    if (rd_start) begin
      n.oe_n = 16'hff00;
      unique case (q.addr_s2)
        PORT_DATA: begin
          n.oe_n = 16'h0000;
          n.dout = q.buffer[q.rptr];
        end
        PORT_ERROR:   n.dout = {8'h00, q.err};
        PORT_SCOUNT:  n.dout = {8'h00, q.scnt};
        PORT_SNUM:    n.dout = {8'h00, q.snum};
        PORT_CYL_LO:  n.dout = {8'h00, q.cyl[7:0]};
        PORT_CYL_HI:  n.dout = {8'h00, q.cyl[15:8]};
        PORT_DRVHEAD: n.dout = {8'h00, q.dh};
        PORT_STATUS: begin
          n.dout = {8'h00, status_byte(q)};
          n.irq_pend = 1'b0;
        end
        PORT_ALT_CTL: n.dout = {8'h00, status_byte(q)};
        PORT_DRV_IN: begin
          n.oe_n = 16'hff80;
          n.dout = {8'h00, 1'b0, q.wg_s2, ~q.dh[3:0],
                    ~q.dh[DH_UNIT_BIT], q.dh[DH_UNIT_BIT]};
        end
        default: n.oe_n = 16'hffff;
      endcase
    end

    // host writes; the task file is frozen while busy
    if (wr_end) begin
      if (q.addr_s2 == PORT_ALT_CTL) begin
        n.soft_reset_bit = q.din_s2[DC_SOFT_RESET_BIT];
        n.mask = q.din_s2[DC_IRQ_MASK_BIT];
      end else if (!q.busy) begin
        unique case (q.addr_s2)
          PORT_SCOUNT:  n.scnt = q.din_s2[7:0];
          PORT_SNUM:    n.snum = q.din_s2[7:0];
          PORT_CYL_LO:  n.cyl[7:0] = q.din_s2[7:0];
          PORT_CYL_HI:  n.cyl[15:8] = q.din_s2[7:0];
          PORT_DRVHEAD: n.dh = q.din_s2[7:0];
          PORT_STATUS: begin
            n.busy = 1'b1;
            n.irq_pend = 1'b0;
            n.err = 8'h00;
            n.errb = 1'b0;
            n.failed = 1'b0;
            n.wptr = '0;
            n.rptr = '0;
            n.remain = count_req;
            n.lng = q.din_s2[7:0] == CMD_READ_LONG || q.din_s2[7:0] == CMD_READ_LNR;
            n.verify = q.din_s2[7:0] == CMD_VERIFY || q.din_s2[7:0] == CMD_VERIFY_NR;
            n.dma = q.din_s2[7:0] == CMD_DMA || q.din_s2[7:0] == CMD_DMA_NR;
            unique case (q.din_s2[7:0])
              CMD_READ, CMD_READ_NR, CMD_READ_LONG, CMD_READ_LNR,
              CMD_VERIFY, CMD_VERIFY_NR, CMD_DMA, CMD_DMA_NR: begin
                if (n.lng && q.scnt != 8'h01) begin
                  n.err[ER_ABRT_BIT] = 1'b1;
                  n.errb = 1'b1;
                  fin = 1'b1;
                  fin_irq = 1'b1;
                end else if (q.cyl != q.cur_cyl) begin
                  n.seek_go = 1'b1;
                  n.state = ST_SEEK;
                end else begin
                  n.media_go = 1'b1;
                  n.state = ST_MEDIA;
                end
              end
              default: begin
                n.err[ER_ABRT_BIT] = 1'b1;
                n.errb = 1'b1;
                fin = 1'b1;
                fin_irq = 1'b1;
              end
            endcase
            if (n.verify) n.lng = 1'b0;
          end
          default: ;
        endcase
      end
    end

    // ========================================================================
    // command engine
    unique case (q.state)
      ST_INIT: begin
        n.init_cnt = q.init_cnt + 16'h0001;
        if (q.init_cnt >= 16'(INIT_CYCLES - 1)) begin
          n.busy = 1'b0;
          n.drdy = 1'b1;
          n.dsc = 1'b1;
          n.state = ST_IDLE;
        end
      end
      // a drained command rests here one cycle with busy shown, then lets go
      ST_IDLE: if (q.busy) n.busy = 1'b0;
      ST_SEEK: if (seek_done) begin
        n.cur_cyl = q.cyl;
        n.media_go = 1'b1;
        n.state = ST_MEDIA;
      end
      ST_MEDIA: begin
        if (media_valid && q.wptr < PW'(DEPTH)) begin
          n.buffer[q.wptr] = media_word;
          n.wptr = q.wptr + PW'(1);
        end
        if (media_end) begin
          if (media_dam_err) begin
            n.err[ER_AMNF_BIT] = 1'b1;
            n.errb = 1'b1;
            fin = 1'b1;
            fin_irq = 1'b1;
          end else begin
            if (media_data_err && !q.lng) begin
              n.err[ER_UNC_BIT] = 1'b1;
              n.errb = 1'b1;
              n.failed = 1'b1;
            end
            if (q.verify) begin
              if (n.failed || q.remain == 9'h001) begin
                fin = 1'b1;
                fin_irq = 1'b1;
              end else begin
                {n.cyl, n.dh[3:0], n.snum} = next_addr(q.snum, q.dh[3:0], q.cyl);
                n.remain = q.remain - 9'h001;
                n.wptr = '0;
                n.media_go = 1'b1;
              end
            end else if (q.dma && n.failed) begin
              fin = 1'b1;
              fin_irq = 1'b1;
            end else begin
              n.drq = 1'b1;
              n.busy = 1'b0;
              n.rptr = '0;
              if (!q.dma) n.irq_pend = 1'b1;
              n.state = q.dma ? ST_DMA : ST_PIO;
            end
          end
        end
      end
      ST_PIO, ST_DMA: begin
        if ((q.state == ST_PIO && rd_start && q.addr_s2 == PORT_DATA) ||
            (q.state == ST_DMA && !q.um_s2 && rd_start && q.ack_s2 &&
             q.addr_s2 == PORT_DATA)) begin
          n.rptr = q.rptr + PW'(1);
          if (last_word) begin
            n.drq = 1'b0;
            n.busy = 1'b1;
          end
        end else if (q.state == ST_DMA && q.um_s2 && q.lreq == q.lack_s2) begin
          if (q.rptr < q.wptr) begin
            n.lword = q.buffer[q.rptr];
            n.lreq = ~q.lreq;
            n.rptr = q.rptr + PW'(1);
          end else begin
            n.drq = 1'b0;
            n.busy = 1'b1;
          end
        end
        // buffer drained: next sector, or end of command
        if (q.drq && !n.drq) begin
          if (q.failed || q.remain == 9'h001) begin
            n.state = ST_IDLE;                                // busy held one cycle there
            fin_irq = q.dma;
          end else begin
            {n.cyl, n.dh[3:0], n.snum} = next_addr(q.snum, q.dh[3:0], q.cyl);
            n.remain = q.remain - 9'h001;
            n.wptr = '0;
            n.media_go = 1'b1;
            n.state = ST_MEDIA;
          end
        end
      end
    endcase

    if (fin) begin
      n.busy = 1'b0;
      n.drq = 1'b0;
      n.state = ST_IDLE;
    end
    if (fin_irq) n.irq_pend = 1'b1;

    // hardware or soft reset: reinitialise and hold busy
    hw_clear = q.hrst_s2 | n.soft_reset_bit;
    if (hw_clear) begin
      n.err = ERROR_RST;
      n.scnt = SCOUNT_RST;
      n.snum = SNUM_RST;
      n.cyl[7:0] = CYL_LO_RST;
      n.dh = DRVHEAD_RST;
      n.busy = 1'b1;
      n.drdy = 1'b0;
      n.drq = 1'b0;
      n.errb = 1'b0;
      n.irq_pend = 1'b0;
      n.init_cnt = 16'h0000;
      n.state = ST_INIT;
      n.wptr = '0;
      n.rptr = '0;
    end
    n.dmarq = n.state == ST_DMA && !q.um_s2 && n.rptr < n.wptr;
    n.burst = n.state == ST_DMA && q.um_s2;
  end

  // ==========================================================================
  // power-on reset forces the initialising state
  always_ff @(posedge clock) begin
    if (reset) begin
      q <= '0;
      q.busy <= 1'b1;
      q.err <= ERROR_RST;
      q.scnt <= SCOUNT_RST;
      q.snum <= SNUM_RST;
      q.oe_n <= 16'hffff;
      q.mask <= 1'b0;
    end else begin
      q <= n;
    end
  end

  udma_link u_link (
    .link_clock   (link_clock),
    .reset        (reset),
    .burst        (q.burst),
    .req_toggle   (q.lreq),
    .word         (q.lword),
    .ack_toggle   (udma_ack),
    .udma_dd      (udma_dd),
    .udma_dd_oe_n (udma_dd_oe_n),
    .udma_dstrobe (udma_dstrobe)
  );

  // interrupt line is released entirely while masked
  assign host_irq      = q.irq_pend & ~q.mask;
  assign host_irq_oe_n = q.mask;
  assign dd_out        = q.dout;
  assign dd_oe_n       = q.oe_n;
  assign dmarq         = q.dmarq;
  assign seek_start    = q.seek_go;
  assign seek_cyl      = q.cyl;
  assign media_start   = q.media_go;
  assign media_cyl     = q.cyl;
  assign media_head    = q.dh[3:0];
  assign media_sector  = q.snum;
  assign media_long    = q.lng;
  assign media_retry   = ~q.din_s2[0];

  // ==========================================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  a_alt_keeps_irq: assert property ((rd_start && q.addr_s2 == PORT_ALT_CTL &&
    q.irq_pend && !hw_clear && !wr_end) |=> q.irq_pend) else $error("alt status cleared irq");
  a_soft_reset_bit_busy_hold: assert property (q.soft_reset_bit |=> q.busy && q.state == ST_INIT)
    else $error("soft reset not holding busy");
  a_unmask_delivers: assert property (($fell(q.mask) && q.irq_pend) |->
    host_irq && !host_irq_oe_n) else $error("pending irq not delivered");
  a_init_no_irq: assert property (($fell(q.busy) && $past(q.state == ST_INIT))
    |-> !q.irq_pend) else $error("irq after reset");
  a_drive_state_read: assert property ((rd_start && q.addr_s2 == PORT_DRV_IN) |=>
    q.dout[5:2] == ~$past(q.dh[3:0]) && q.oe_n[7] && !q.oe_n[6])
    else $error("drive state read wrong");
  a_status_clears: assert property ((rd_start && q.addr_s2 == PORT_STATUS &&
    q.state == ST_IDLE && !wr_end) |=> !q.irq_pend) else $error("status read kept irq");
  a_empty_sets_busy: assert property ((q.state == ST_PIO && rd_start &&
    q.addr_s2 == PORT_DATA && last_word) |=> !q.drq && q.busy)
    else $error("empty buffer did not set busy");
  a_hwreset_taskfile: assert property (q.hrst_s2 |=> q.scnt == SCOUNT_RST &&
    q.snum == SNUM_RST && q.err == ERROR_RST && q.dh == DRVHEAD_RST && q.busy)
    else $error("task file not reset");
  a_long_single: assert property ((wr_end && !q.busy && !hw_clear &&
    q.addr_s2 == PORT_STATUS && q.din_s2[7:0] == CMD_READ_LONG && q.scnt != 8'h01)
    |=> q.errb && q.err[ER_ABRT_BIT] && !q.busy) else $error("multi-sector long accepted");
  a_cmd_busy: assert property ((wr_end && !q.busy && !hw_clear &&
    q.addr_s2 == PORT_STATUS && q.din_s2[7:0] == CMD_READ) |=> q.busy ##1 q.busy)
    else $error("command did not set busy");

  c_pio_sector: cover property (q.state == ST_PIO ##[1:1000] q.state == ST_IDLE);
  c_dma_end: cover property (q.state == ST_DMA ##[1:1000] q.state == ST_IDLE);
  c_abort: cover property (q.err[ER_ABRT_BIT] && q.errb);
endmodule : disk_host_port

// ### logic/disk_pkg.sv
package disk_pkg;
  // ==========================================================================
  // host port addresses
  localparam logic [9:0] PORT_DATA    = 10'h1f0;
  localparam logic [9:0] PORT_ERROR   = 10'h1f1;
  localparam logic [9:0] PORT_SCOUNT  = 10'h1f2;
  localparam logic [9:0] PORT_SNUM    = 10'h1f3;
  localparam logic [9:0] PORT_CYL_LO  = 10'h1f4;
  localparam logic [9:0] PORT_CYL_HI  = 10'h1f5;
  localparam logic [9:0] PORT_DRVHEAD = 10'h1f6;
  localparam logic [9:0] PORT_STATUS  = 10'h1f7;
  localparam logic [9:0] PORT_ALT_CTL = 10'h3f6;
  localparam logic [9:0] PORT_DRV_IN  = 10'h3f7;
  // ==========================================================================
  // device control fields
  localparam int DC_SOFT_RESET_BIT = 2;
  localparam int DC_IRQ_MASK_BIT   = 1;
  // drive/head fields
  localparam int DH_UNIT_BIT       = 4;
  // error register fields
  localparam int ER_AMNF_BIT       = 0;
  localparam int ER_ABRT_BIT       = 2;
  localparam int ER_UNC_BIT        = 6;
  // ==========================================================================
  // task file values after any reset
  localparam logic [7:0]  ERROR_RST   = 8'h01;
  localparam logic [7:0]  SCOUNT_RST  = 8'h01;
  localparam logic [7:0]  SNUM_RST    = 8'h01;
  localparam logic [7:0]  CYL_LO_RST  = 8'h00;
  localparam logic [7:0]  DRVHEAD_RST = 8'h00;
  // ==========================================================================
  // command codes; bit 0 set means retries off
  localparam logic [7:0] CMD_READ       = 8'h20;
  localparam logic [7:0] CMD_READ_NR    = 8'h21;
  localparam logic [7:0] CMD_READ_LONG  = 8'h22;
  localparam logic [7:0] CMD_READ_LNR   = 8'h23;
  localparam logic [7:0] CMD_VERIFY     = 8'h40;
  localparam logic [7:0] CMD_VERIFY_NR  = 8'h41;
  localparam logic [7:0] CMD_DMA        = 8'hc8;
  localparam logic [7:0] CMD_DMA_NR     = 8'hc9;
  localparam logic [8:0] SECTORS_MAX    = 9'h100;
  // ==========================================================================
  // timing
  localparam int INIT_CYCLES_DEF = 16;
endpackage : disk_pkg

// ### test/media_model.sv
`timescale 1ns/1ns
// ============================================================================
// media side stand-in: answers seeks and streams one sector per start
module media_model #(
  parameter int WORDS = 4
) (
  input  wire logic        clock,
  input  wire logic        seek_start,
  input  wire logic        media_start,
  output      logic        seek_done,
  output      logic        media_valid,
  output      logic [15:0] media_word,
  output      logic        media_end
);
  initial {seek_done, media_valid, media_end, media_word} = '0;
  // the arm is never instant, so the wait for seek_done is really exercised
  always @(posedge clock) if (seek_start) begin
    repeat (3) @(posedge clock);
    seek_done <= 1'b1;
    @(posedge clock) seek_done <= 1'b0;
  end
  // word pattern a000+i; the bus shows inverted junk once valid drops
  always @(posedge clock) if (media_start) begin
    repeat (2) @(posedge clock);
    for (int i = 0; i < WORDS; i++) begin
      media_valid <= 1'b1;
      media_word  <= 16'ha000 + 16'(i);
      @(posedge clock);
    end
    media_valid <= 1'b0;
    media_word  <= ~media_word;
    media_end   <= 1'b1;
    @(posedge clock) media_end <= 1'b0;
  end
endmodule : media_model

// ### test/test_disk_host_port.sv
`timescale 1ns/1ns
module test_disk_host_port;
  import disk_pkg::*;
  logic        clock = 0, reset = 1, link_clock = 0, rd_n = 1, wr_n = 1, bad = 0;
  logic [9:0]  host_addr = 10'h000;
  logic [15:0] dd_in = 16'h0000, dd_out, dd_oe_n, rdata, roe, media_word;
  logic        host_irq, host_irq_oe_n, seek_start, seek_done;
  logic        hrst_n = 1, wg = 1, dmack_n = 1, dam = 0, dmarq;
  logic        media_start, media_valid, media_end;
  int          num_errors = 0, cmp_count = 0, cyc = 0;
  always #25 clock = ~clock;
  always begin
    #7 link_clock = 1'b1;
    #8 link_clock = 1'b0;
  end
  disk_host_port #(.SECTOR_WORDS(4), .INIT_CYCLES(4)) dut (.clock(clock), .reset(reset),
    .link_clock(link_clock), .host_reset_n(hrst_n), .host_addr(host_addr), .host_rd_n(rd_n),
    .host_wr_n(wr_n), .dd_in(dd_in), .dd_out(dd_out), .dd_oe_n(dd_oe_n),
    .host_irq(host_irq), .host_irq_oe_n(host_irq_oe_n), .dmarq(dmarq), .dmack_n(dmack_n),
    .udma_mode(1'b0), .udma_dd(), .udma_dd_oe_n(), .udma_dstrobe(), .write_gate_n(wg),
    .seek_start(seek_start), .seek_cyl(), .seek_done(seek_done), .media_start(media_start),
    .media_cyl(), .media_head(), .media_sector(), .media_long(), .media_retry(),
    .media_valid(media_valid), .media_word(media_word), .media_end(media_end),
    .media_dam_err(dam), .media_data_err(bad));
  media_model #(.WORDS(4)) far (.clock(clock), .seek_start(seek_start),
    .media_start(media_start), .seek_done(seek_done), .media_valid(media_valid),
    .media_word(media_word), .media_end(media_end));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // strobes held 5 cycles low and high, above the 4 cycle minimum
  task automatic rd(input logic [9:0] a);
    @(negedge clock) host_addr = a;
    rd_n = 1'b0;
    repeat (5) @(negedge clock);
    rdata = dd_out;
    roe = dd_oe_n;
    rd_n = 1'b1;
    repeat (5) @(negedge clock);
  endtask : rd
  task automatic rchk(input logic [9:0] a, input logic [7:0] e);
    rd(a);
    check({8'h00, rdata[7:0]}, {8'h00, e});
  endtask : rchk
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(negedge clock) host_addr = a;
    dd_in = {8'h00, d};
    wr_n = 1'b0;
    repeat (5) @(negedge clock);
    wr_n = 1'b1;
    repeat (5) @(negedge clock);
  endtask : wr
  task automatic wait_ready;
    for (int i = 0; i < 60; i++) begin
      rd(PORT_ALT_CTL);
      if (rdata[7] === 1'b0) break;
    end
  endtask : wait_ready
  task automatic wait_irq;
    for (int i = 0; i < 400 && host_irq !== 1'b1; i++) @(negedge clock);
  endtask : wait_irq
  task automatic words;
    for (int i = 0; i < 4; i++) begin
      rd(PORT_DATA);
      check(rdata, 16'ha000 + 16'(i));
    end
  endtask : words
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  // a hang is cut short far beyond the fewer than a thousand cycles the run needs
  always @(posedge clock) if (++cyc == 20000) begin
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (20) @(negedge clock);
    reset = 1'b0;
    wait_ready();
    check({8'h00, rdata[7:0]}, 16'h0050);
    rchk(PORT_ERROR, 8'h01);
    rchk(PORT_SCOUNT, 8'h01);
    rchk(PORT_SNUM, 8'h01);
    rchk(PORT_CYL_LO, 8'h00);
    rchk(PORT_DRVHEAD, 8'h00);
    rd(PORT_DRV_IN);
    check(roe, 16'hff80);
    check({9'h000, rdata[6:0]}, 16'h007e);
    wg = 1'b0;
    wr(PORT_DRVHEAD, 8'h13);
    rd(PORT_DRV_IN);
    check({9'h000, rdata[6:0]}, 16'h0031);
    $display("test reset and drive state done");
    wr(PORT_SCOUNT, 8'h01);
    wr(PORT_STATUS, CMD_READ);
    wait_irq();
    rchk(PORT_ALT_CTL, 8'h58);
    check({15'h0, host_irq}, 16'h0001);
    wr(PORT_ALT_CTL, 8'h02);
    check({15'h0, host_irq_oe_n}, 16'h0001);
    wr(PORT_ALT_CTL, 8'h00);
    check({14'h0, host_irq, host_irq_oe_n}, 16'h0002);
    rchk(PORT_STATUS, 8'h58);
    check({15'h0, host_irq}, 16'h0000);
    words();
    wait_ready();
    check({7'h00, host_irq, rdata[7:0]}, 16'h0050);
    $display("test sector read done");
    bad = 1'b1;
    wr(PORT_SCOUNT, 8'h02);
    wr(PORT_STATUS, CMD_READ_NR);
    wait_irq();
    rchk(PORT_STATUS, 8'h59);
    rchk(PORT_ERROR, 8'h40);
    words();
    rchk(PORT_SNUM, 8'h01);
    bad = 1'b0;
    wait_ready();
    wr(PORT_STATUS, 8'hff);
    wait_irq();
    rchk(PORT_ERROR, 8'h04);
    $display("test errors done");
    dmack_n = 1'b0;
    wr(PORT_SCOUNT, 8'h01);
    wr(PORT_STATUS, CMD_DMA);
    for (int i = 0; i < 400 && dmarq !== 1'b1; i++) @(negedge clock);
    check({15'h0, dmarq}, 16'h0001);
    check({15'h0, host_irq}, 16'h0000);
    words();
    wait_irq();
    check({15'h0, dmarq}, 16'h0000);
    rchk(PORT_STATUS, 8'h50);
    dmack_n = 1'b1;
    wr(PORT_CYL_LO, 8'h05);
    wr(PORT_SCOUNT, 8'h02);
    wr(PORT_STATUS, CMD_VERIFY);
    wait_irq();
    rchk(PORT_STATUS, 8'h50);
    rchk(PORT_SNUM, 8'h02);
    wr(PORT_STATUS, CMD_READ_LONG);
    wait_irq();
    rchk(PORT_ERROR, 8'h04);
    hrst_n = 1'b0;
    repeat (5) @(negedge clock);
    check({15'h0, host_irq}, 16'h0000);
    rd(PORT_ALT_CTL);
    check({15'h0, rdata[7]}, 16'h0001);
    hrst_n = 1'b1;
    wait_ready();
    check({7'h00, host_irq, rdata[7:0]}, 16'h0050);
    rchk(PORT_SCOUNT, 8'h01);
    rchk(PORT_SNUM, 8'h01);
    $display("test dma, verify and host reset done");
    dam = 1'b1;
    wr(PORT_STATUS, CMD_READ);
    wait_irq();
    rchk(PORT_STATUS, 8'h51);
    rchk(PORT_ERROR, 8'h01);
    dam = 1'b0;
    $display("test missing mark done");
    wr(PORT_ALT_CTL, 8'h04);
    repeat (100) @(negedge clock);
    rd(PORT_ALT_CTL);
    check({15'h0, rdata[7]}, 16'h0001);
    wr(PORT_ALT_CTL, 8'h00);
    wait_ready();
    check({7'h00, host_irq, rdata[7:0]}, 16'h0050);
    rchk(PORT_ERROR, 8'h01);
    $display("test soft reset done");
    print_verdict();
  end
endmodule : test_disk_host_port
